// File: acsr_pkg.sv
// constants and carrier types for the converter configuration registers
// ****************************************************************
// Summary of operation
// - bits 3:1 choose input: open, two single-ended, differential, sensors
// - bits 5:4 choose single-ended bias, 10b low, 11b high; reset 11b
// - bits 7:6 choose decimation 200, 100, 64, 32; reset gives 32
// - bits 9:8 choose attenuation 0, 6.02 or 9.54 dB
// - bit 11 picks single or continuous conversion; resets to one
// - bit 18 set bypasses the comb filter
// - bit 0 selects common-mode current nulling; resets to one
// - bit 20 picks microphone clock rate, 0.8 or 1.6 MHz
// - bit 21 set skips the wake-up wait before conversion
// - bit 22 set drives the microphone clock out
// - calibration-done flag sets on calibration end, cleared by read
// - busy flag sets during conversion, read clears only once idle
// - end-of-conversion flag sets on completion, cleared by read
// - window flag sets when result is inside thresholds with comparator enabled, read clears
// - mask bits 0..3, zero enables; all reset to one
// - read-only 32-bit two's complement result, resets to zero
// - 32-bit read-write offset, reset zero, corrects converted data
// - status calibration bit sets and offset takes calibration result
// - status bit 1 shows busy, bit 2 shows completed conversion
// - status bit 3 shows result inside window when comparator enabled
// - high threshold register read-write with printed reset value
// - control bit 5 enables the window comparator
// - control bit 2 starts conversion when software sets it
// ****************************************************************
package acsr_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_IRQST = 8'h08;
  localparam logic [7:0] ADDR_IRQMSK = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h14;
  localparam logic [7:0] ADDR_OFFS = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_WINHI = 8'h24;
  localparam logic [7:0] ADDR_WINLO = 8'h28;
  // reserved config bits read back as ones
  localparam logic [31:0] CFG_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] CFG_WMASK = 32'h0074_0BFF;
  localparam logic [31:0] MASK_RST = 32'h0000_000F;
  localparam logic [31:0] WINHI_RST = 32'h0FFF_FFFF;
  localparam logic [31:0] WINLO_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam int CFG_CMNULL = 0;
  localparam int CFG_SRC_LSB = 1;
  localparam int CFG_BIAS_LSB = 4;
  localparam int CFG_DEC_LSB = 6;
  localparam int CFG_ATT_LSB = 8;
  localparam int CFG_REPEAT = 11;
  localparam int CFG_COMB = 18;
  localparam int CFG_MICRATE = 20;
  localparam int CFG_SKIPWAKE = 21;
  localparam int CFG_MICOUT = 22;
  localparam int CTRL_TRIG = 2;
  localparam int CTRL_WCMP = 5;
  localparam int FLG_CAL = 0;
  localparam int FLG_BUSY = 1;
  localparam int FLG_EOC = 2;
  localparam int FLG_WIN = 3;
  localparam int CLK_NS = 20;
  localparam int SYS_KHZ = 50000;
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIC_SLOW_KHZ = 800;
  localparam int MIC_FAST_KHZ = 1600;
  localparam int MIC_SLOW_HALF = SYS_KHZ / (2 * MIC_SLOW_KHZ);
  localparam int MIC_FAST_HALF = SYS_KHZ / (2 * MIC_FAST_KHZ);

  typedef enum logic [1:0] {
    SRC_OPEN, SRC_SE2, SRC_SE1, SRC_DIFF
  } acsr_dummy_t;

  typedef struct packed {
    logic commonModeNull;
    logic [2:0] inputSourceSelect;
    logic [1:0] singleEndedBiasSelect;
    logic [1:0] decimationRatio;
    logic [1:0] inputAttenuation;
    logic repeatConversion;
    logic combBypass;
    logic micClockRate;
    logic skipWakeupDelay;
    logic micClockOutput;
  } acsr_cfg_t;

  typedef struct packed {
    logic calibrationDone;
    logic [31:0] calResult;
    logic convBusy;
    logic convDone;
    logic [31:0] rawData;
  } acsr_core_t;
endpackage

// File: acsr_regs.sv
// apb register block for converter configuration, status and result
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module acsr_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acsr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire acsr_pkg::acsr_core_t coreIn,
  output acsr_pkg::acsr_cfg_t cfgOut,
  output logic convStart,
  output logic micClk,
  output logic micClkEn,
  output logic irq
);
  import acsr_pkg::*;

  typedef enum logic {ST_IDLE, ST_WAKE} acsr_trig_t;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CTRL, ADDR_CFG, ADDR_IRQST, ADDR_IRQMSK, ADDR_RESULT,
      ADDR_OFFS, ADDR_STATUS, ADDR_WINHI, ADDR_WINLO: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic setupRd, accWr, accRd, accOk;
  assign setupRd = psel && !penable && !pwrite;
  assign accOk = psel && penable && isMapped(paddr);
  assign accWr = accOk && pwrite;
  assign accRd = accOk && !pwrite;
  // zero wait states: read data is captured during setup
  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);

  logic [31:0] ctrl_r, cfg_r, mask_r, result_r, offs_r, winHi_r, winLo_r;
  logic [3:0] irqFlag_r, irqSnap_r;
  logic calStat_r, eocStat_r, winStat_r;
  logic [31:0] rdMux;

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CFG_RST;
    end else if (accWr && paddr == ADDR_CFG) begin
      cfg_r <= (cfg_r & ~CFG_WMASK) | (pwdata & CFG_WMASK);
    end
  end

  // the trigger bit is self-clearing so one write gives one start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= ZERO_RST;
    end else if (accWr && paddr == ADDR_CTRL) begin
      ctrl_r <= pwdata;
    end else begin
      ctrl_r[CTRL_TRIG] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_r <= MASK_RST;
    end else if (accWr && paddr == ADDR_IRQMSK) begin
      mask_r <= {28'h000_0000, pwdata[3:0]};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      winHi_r <= WINHI_RST;
      winLo_r <= WINLO_RST;
    end else if (accWr && paddr == ADDR_WINHI) begin
      winHi_r <= pwdata;
    end else if (accWr && paddr == ADDR_WINLO) begin
      winLo_r <= pwdata;
    end
  end

  // calibration result overrides a software write in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      offs_r <= ZERO_RST;
    end else if (coreIn.calibrationDone) begin
      offs_r <= coreIn.calResult;
    end else if (accWr && paddr == ADDR_OFFS) begin
      offs_r <= pwdata;
    end
  end

  // ****************************************************************
  // configuration to the analog core
  // ****************************************************************
  always_comb begin
    cfgOut.commonModeNull = cfg_r[CFG_CMNULL];
    cfgOut.inputSourceSelect = cfg_r[CFG_SRC_LSB +: 3];
    cfgOut.singleEndedBiasSelect = cfg_r[CFG_BIAS_LSB +: 2];
    cfgOut.decimationRatio = cfg_r[CFG_DEC_LSB +: 2];
    cfgOut.inputAttenuation = cfg_r[CFG_ATT_LSB +: 2];
    cfgOut.repeatConversion = cfg_r[CFG_REPEAT];
    cfgOut.combBypass = cfg_r[CFG_COMB];
    cfgOut.micClockRate = cfg_r[CFG_MICRATE];
    cfgOut.skipWakeupDelay = cfg_r[CFG_SKIPWAKE];
    cfgOut.micClockOutput = cfg_r[CFG_MICOUT];
  end

  // ****************************************************************
  // start sequencing with optional wake-up wait
  // ****************************************************************
  acsr_trig_t trig_r;
  logic [7:0] wakeCnt_r;
  logic convStart_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_r <= ST_IDLE;
      wakeCnt_r <= 8'h00;
      convStart_r <= 1'b0;
    end else begin
      convStart_r <= 1'b0;
      case (trig_r)
        ST_IDLE: begin
          if (ctrl_r[CTRL_TRIG]) begin
            if (cfg_r[CFG_SKIPWAKE]) begin
              convStart_r <= 1'b1;
            end else begin
              trig_r <= ST_WAKE;
              wakeCnt_r <= 8'(WAKE_CYC - 1);
            end
          end
        end
        ST_WAKE: begin
          if (wakeCnt_r == 8'h00) begin
            convStart_r <= 1'b1;
            trig_r <= ST_IDLE;
          end else begin
            wakeCnt_r <= wakeCnt_r - 8'h01;
          end
        end
        default: trig_r <= ST_IDLE;
      endcase
    end
  end
  assign convStart = convStart_r;

  // ****************************************************************
  // result, offset correction and window comparator
  // ****************************************************************
  logic [31:0] corrected;
  logic inWindow;
  assign corrected = coreIn.rawData - offs_r;
  assign inWindow = ctrl_r[CTRL_WCMP] &&
    ($signed(corrected) >= $signed(winLo_r)) &&
    ($signed(corrected) <= $signed(winHi_r));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_r <= ZERO_RST;
      winStat_r <= 1'b0;
    end else if (coreIn.convDone) begin
      result_r <= corrected;
      winStat_r <= inWindow;
    end else if (!ctrl_r[CTRL_WCMP]) begin
      winStat_r <= 1'b0;
    end
  end

  // calibration and end status bits hold until written with one; a new event wins the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      calStat_r <= 1'b0;
      eocStat_r <= 1'b0;
    end else begin
      calStat_r <= coreIn.calibrationDone || (calStat_r &&
        !(accWr && paddr == ADDR_STATUS && pwdata[FLG_CAL]));
      eocStat_r <= coreIn.convDone || (eocStat_r &&
        !(accWr && paddr == ADDR_STATUS && pwdata[FLG_EOC]));
    end
  end

  // ****************************************************************
  // clear-on-read interrupt flags
  // ****************************************************************
  logic [3:0] irqSet, irqClr;
  assign irqSet = {coreIn.convDone && inWindow, coreIn.convDone,
    coreIn.convBusy, coreIn.calibrationDone};
  // only bits seen by the read are cleared, so late events survive
  always_comb begin
    irqClr = 4'h0;
    if (accRd && paddr == ADDR_IRQST) begin
      irqClr = irqSnap_r;
      irqClr[FLG_BUSY] = irqSnap_r[FLG_BUSY] && !coreIn.convBusy;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqFlag_r <= 4'h0;
    end else begin
      irqFlag_r <= (irqFlag_r & ~irqClr) | irqSet;
    end
  end

  assign irq = |(irqFlag_r & ~mask_r[3:0]);

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    case (paddr)
      ADDR_CTRL: rdMux = ctrl_r;
      ADDR_CFG: rdMux = cfg_r;
      ADDR_IRQST: rdMux = {28'h000_0000, irqFlag_r};
      ADDR_IRQMSK: rdMux = mask_r;
      ADDR_RESULT: rdMux = result_r;
      ADDR_OFFS: rdMux = offs_r;
      ADDR_STATUS: rdMux = {28'h000_0000, winStat_r, eocStat_r,
        coreIn.convBusy, calStat_r};
      ADDR_WINHI: rdMux = winHi_r;
      ADDR_WINLO: rdMux = winLo_r;
      default: rdMux = ZERO_RST;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= ZERO_RST;
      irqSnap_r <= 4'h0;
    end else if (setupRd) begin
      prdata <= rdMux;
      irqSnap_r <= irqFlag_r;
    end
  end

  // ****************************************************************
  // microphone clock divider
  // ****************************************************************
  logic [4:0] micCnt_r;
  logic micClk_r;
  logic [4:0] micHalf;
  assign micHalf = cfg_r[CFG_MICRATE] ? 5'(MIC_FAST_HALF - 1)
    : 5'(MIC_SLOW_HALF - 1);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      micCnt_r <= 5'h00;
      micClk_r <= 1'b0;
    end else if (!cfg_r[CFG_MICOUT]) begin
      micCnt_r <= 5'h00;
      micClk_r <= 1'b0;
    end else if (micCnt_r >= micHalf) begin
      micCnt_r <= 5'h00;
      micClk_r <= !micClk_r;
    end else begin
      micCnt_r <= micCnt_r + 5'h01;
    end
  end
  assign micClk = micClk_r;
  assign micClkEn = cfg_r[CFG_MICOUT];

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_calOffset;
    @(posedge sys_clk) disable iff (rst)
    coreIn.calibrationDone |=> offs_r == $past(coreIn.calResult) && calStat_r;
  endproperty
  a_calOffset: assert property (p_calOffset)
    else $error("offset not loaded by calibration");

  property p_resultLoad;
    @(posedge sys_clk) disable iff (rst)
    coreIn.convDone |=> result_r == $past(corrected) && irqFlag_r[FLG_EOC];
  endproperty
  a_resultLoad: assert property (p_resultLoad)
    else $error("result or end flag not updated");

  property p_irqOr;
    @(posedge sys_clk) disable iff (rst)
    coreIn.convDone && !mask_r[FLG_EOC]
      && !(accWr && paddr == ADDR_IRQMSK) |=> irq;
  endproperty
  a_irqOr: assert property (p_irqOr)
    else $error("unmasked end event gave no interrupt");

  property p_busyHold;
    @(posedge sys_clk) disable iff (rst)
    coreIn.convBusy |=> irqFlag_r[FLG_BUSY];
  endproperty
  a_busyHold: assert property (p_busyHold)
    else $error("busy flag cleared while busy");

  property p_calClear;
    @(posedge sys_clk) disable iff (rst)
    accRd && paddr == ADDR_IRQST && irqSnap_r[FLG_CAL]
      && !coreIn.calibrationDone |=> !irqFlag_r[FLG_CAL];
  endproperty
  a_calClear: assert property (p_calClear)
    else $error("calibration flag survived read");

  property p_winOff;
    @(posedge sys_clk) disable iff (rst)
    !ctrl_r[CTRL_WCMP] |=> !winStat_r;
  endproperty
  a_winOff: assert property (p_winOff)
    else $error("window status set with comparator off");

  property p_winFlag;
    @(posedge sys_clk) disable iff (rst)
    coreIn.convDone && inWindow |=> irqFlag_r[FLG_WIN] && winStat_r;
  endproperty
  a_winFlag: assert property (p_winFlag)
    else $error("window match not flagged");

  property p_skipWake;
    @(posedge sys_clk) disable iff (rst)
    trig_r == ST_IDLE && ctrl_r[CTRL_TRIG] && cfg_r[CFG_SKIPWAKE]
      |=> convStart;
  endproperty
  a_skipWake: assert property (p_skipWake)
    else $error("start delayed despite skip");

  property p_wakeWait;
    @(posedge sys_clk) disable iff (rst)
    trig_r == ST_IDLE && ctrl_r[CTRL_TRIG] && !cfg_r[CFG_SKIPWAKE]
      |=> !convStart [*8];
  endproperty
  a_wakeWait: assert property (p_wakeWait)
    else $error("start issued before wake-up wait");

  property p_micOff;
    @(posedge sys_clk) disable iff (rst)
    !cfg_r[CFG_MICOUT] |=> !micClk;
  endproperty
  a_micOff: assert property (p_micOff)
    else $error("microphone clock toggles while disabled");

  property p_busyClear;
    @(posedge sys_clk) disable iff (rst)
    accRd && paddr == ADDR_IRQST && irqSnap_r[FLG_BUSY]
      && !coreIn.convBusy |=> !irqFlag_r[FLG_BUSY];
  endproperty
  a_busyClear: assert property (p_busyClear)
    else $error("busy flag survived read after busy ended");

  property p_eocClear;
    @(posedge sys_clk) disable iff (rst)
    accRd && paddr == ADDR_IRQST && irqSnap_r[FLG_EOC]
      && !coreIn.convDone |=> !irqFlag_r[FLG_EOC];
  endproperty
  a_eocClear: assert property (p_eocClear)
    else $error("end flag survived read");

  // an inverted window holds nothing, so only an ordered one is checked
  property p_winEdge;
    @(posedge sys_clk) disable iff (rst)
    coreIn.convDone && ctrl_r[CTRL_WCMP]
      && $signed(winLo_r) <= $signed(winHi_r)
      && (corrected == winHi_r || corrected == winLo_r) |=> winStat_r;
  endproperty
  a_winEdge: assert property (p_winEdge)
    else $error("result on a bound not taken as inside");

  property p_trigOnce;
    @(posedge sys_clk) disable iff (rst)
    ctrl_r[CTRL_TRIG] && !(accWr && paddr == ADDR_CTRL)
      |=> !ctrl_r[CTRL_TRIG];
  endproperty
  a_trigOnce: assert property (p_trigOnce)
    else $error("trigger bit did not self-clear");
endmodule

// File: acsr_tb.sv
// self-checking bench for the converter register block
`timescale 1ns/1ps
module tb;
  import acsr_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, cw, ex;
  acsr_core_t coreIn;
  acsr_cfg_t cfgOut;
  logic convStart, micClk, micClkEn, irq, lastErr;
  int n_mismatch, comparisons, cyc, d0, d1, per;

  acsr_regs u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreIn(coreIn),
    .cfgOut(cfgOut), .convStart(convStart), .micClk(micClk),
    .micClkEn(micClkEn), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    check(32'(lastErr), 32'h0000_0000, "mapped write error");
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string what);
    xfer(a, 1'b0, 32'h0000_0000);
    check(rd, e, what);
  endtask

  task automatic irqchk(input logic e);
    @(posedge sys_clk);
    #1;
    check(32'(irq), 32'(e), "irq level");
  endtask

  // one-cycle event from the converter core; busy drops with it
  task automatic pulse(input logic cal, input logic [31:0] v);
    @(posedge sys_clk);
    coreIn.convBusy <= 1'b0;
    coreIn.calibrationDone <= cal;
    coreIn.convDone <= ~cal;
    coreIn.calResult <= v;
    coreIn.rawData <= v;
    @(posedge sys_clk);
    coreIn.calibrationDone <= 1'b0;
    coreIn.convDone <= 1'b0;
  endtask

  // edges from the trigger write to the start pulse
  task automatic trig(output int d);
    wr(ADDR_CTRL, 32'h0000_0024);
    d = 0;
    do begin
      @(posedge sys_clk);
      #1;
      d++;
    end while (convStart !== 1'b1 && d < 200);
    @(posedge sys_clk);
    #1;
    check(32'(convStart), 32'h0000_0000, "start lasts one cycle");
  endtask

  // cycles between two rising edges of the mic clock, zero if none
  task automatic micper(output int p);
    int t0;
    logic last;
    t0 = -1;
    p = 0;
    last = micClk;
    for (int k = 0; k < 300 && p == 0; k++) begin
      @(posedge sys_clk);
      #1;
      if (micClk === 1'b1 && last === 1'b0) begin
        if (t0 < 0) t0 = k;
        else p = k - t0;
      end
      last = micClk;
    end
  endtask

  function automatic acsr_cfg_t cfgof(input logic [31:0] w);
    acsr_cfg_t c;
    c.commonModeNull = w[CFG_CMNULL];
    c.inputSourceSelect = w[3:1];
    c.singleEndedBiasSelect = w[5:4];
    c.decimationRatio = w[7:6];
    c.inputAttenuation = w[9:8];
    c.repeatConversion = w[CFG_REPEAT];
    c.combBypass = w[CFG_COMB];
    c.micClockRate = w[CFG_MICRATE];
    c.skipWakeupDelay = w[CFG_SKIPWAKE];
    c.micClockOutput = w[CFG_MICOUT];
    return c;
  endfunction

  task final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    coreIn = '0;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    check(32'(micClkEn), 32'h0000_0001, "mic enable reset");
    rdchk(ADDR_CFG, CFG_RST, "cfg reset");
    check(32'(cfgOut), 32'(cfgof(CFG_RST)), "cfg out reset");
    rdchk(ADDR_IRQMSK, MASK_RST, "mask reset");
    rdchk(ADDR_RESULT, ZERO_RST, "result reset");
    rdchk(ADDR_OFFS, ZERO_RST, "offset reset");
    rdchk(ADDR_WINHI, WINHI_RST, "high bound reset");
    rdchk(ADDR_IRQST, ZERO_RST, "irq flags reset");
    rdchk(ADDR_STATUS, ZERO_RST, "status reset");
    for (int i = 0; i < 7; i++) begin
      cw = (32'(i) << 1) | 32'(i % 2) | (32'(2 + i % 2) << 4)
         | (32'(i % 4) << 6) | (32'(i % 3) << 8) | (32'(i % 2) << 11)
         | (32'(i / 2 % 2) << 18) | (32'(i % 2) << 20)
         | (32'(i / 4) << 21) | (32'(1 - i % 2) << 22);
      ex = (cw & CFG_WMASK) | ~CFG_WMASK;
      wr(ADDR_CFG, cw);
      rdchk(ADDR_CFG, ex, "cfg");
      check(32'(cfgOut), 32'(cfgof(cw)), "cfg out");
    end
    wr(ADDR_CFG, 32'h0050_0000);
    micper(per);
    check(32'(per), 32'(2 * MIC_FAST_HALF), "fast mic period");
    wr(ADDR_CFG, 32'h0040_0000);
    micper(per);
    check(32'(per), 32'(2 * MIC_SLOW_HALF), "slow mic period");
    wr(ADDR_CFG, 32'h0000_0000);
    micper(per);
    check(32'(per), 32'h0000_0000, "mic clock idle");
    check(32'(micClkEn), 32'h0000_0000, "mic enable off");
    wr(ADDR_CFG, 32'h0020_0000);
    trig(d0);
    check(32'(d0 >= 1 && d0 <= 2), 32'h0000_0001, "quick start");
    wr(ADDR_CFG, 32'h0000_0000);
    trig(d1);
    check(32'(d1 - d0), 32'(WAKE_CYC), "wake wait");
    rdchk(ADDR_CTRL, 32'h0000_0020, "trigger self clears");
    wr(ADDR_OFFS, 32'h0000_0005);
    rdchk(ADDR_OFFS, 32'h0000_0005, "offset rw");
    wr(ADDR_WINLO, 32'hFFFF_FFF6);
    wr(ADDR_WINHI, 32'h0000_0064);
    coreIn.convBusy <= 1'b1;
    rdchk(ADDR_STATUS, 32'h0000_0002, "busy status");
    rdchk(ADDR_IRQST, 32'h0000_0002, "busy flag");
    rdchk(ADDR_IRQST, 32'h0000_0002, "busy kept while busy");
    pulse(1'b0, 32'h0000_0069);
    rdchk(ADDR_RESULT, 32'h0000_0064, "corrected result");
    rdchk(ADDR_STATUS, 32'h0000_000C, "at high bound");
    irqchk(1'b0);
    wr(ADDR_IRQMSK, 32'h0000_000B);
    irqchk(1'b1);
    rdchk(ADDR_IRQST, 32'h0000_000E, "flags");
    rdchk(ADDR_IRQST, 32'h0000_0000, "read clears");
    irqchk(1'b0);
    pulse(1'b0, 32'h0000_006A);
    rdchk(ADDR_STATUS, 32'h0000_0004, "above window");
    rdchk(ADDR_IRQST, 32'h0000_0004, "no window flag");
    pulse(1'b0, 32'hFFFF_FFFB);
    rdchk(ADDR_STATUS, 32'h0000_000C, "at low bound");
    rdchk(ADDR_IRQST, 32'h0000_000C, "low bound flag");
    wr(ADDR_CTRL, 32'h0000_0000);
    rdchk(ADDR_STATUS, 32'h0000_0004, "window off");
    pulse(1'b0, 32'h0000_0069);
    rdchk(ADDR_IRQST, 32'h0000_0004, "no flag window off");
    wr(ADDR_RESULT, 32'h1234_5678);
    rdchk(ADDR_RESULT, 32'h0000_0064, "result read only");
    wr(ADDR_IRQMSK, 32'h0000_000E);
    pulse(1'b1, 32'h0000_0077);
    irqchk(1'b1);
    rdchk(ADDR_OFFS, 32'h0000_0077, "calibration offset");
    rdchk(ADDR_STATUS, 32'h0000_0005, "calibration status");
    rdchk(ADDR_IRQST, 32'h0000_0001, "calibration flag");
    rdchk(ADDR_IRQST, 32'h0000_0000, "calibration clears");
    wr(ADDR_STATUS, 32'h0000_0005);
    rdchk(ADDR_STATUS, 32'h0000_0000, "status write clears");
    rdchk(8'h30, 32'h0000_0000, "unmapped read");
    check(32'(lastErr), 32'h0000_0001, "unmapped error");
    final_report();
  end
endmodule
